// *** rtl/hesb_defines.vh ***
`ifndef HESB_DEFINES_VH
`define HESB_DEFINES_VH

// register indices; byte address is four times the index
`define HESB_IDX_SUMMARY 4'h0
`define HESB_IDX_STORED 4'h1
`define HESB_IDX_CFG_A 4'h2
`define HESB_IDX_UNIT_B 4'h3
`define HESB_IDX_IRQ_STATUS 4'h4
`define HESB_IDX_IRQ_MASK 4'h5
`define HESB_IDX_UNIT_COUNT 4'h6

// summary word fields
`define HESB_SUM_STORED 0
`define HESB_SUM_CONFIG 1
`define HESB_SUM_CHANNEL 2
`define HESB_SUM_EXP_COMM 4
`define HESB_SUM_IO_ERR 10
`define HESB_SUM_EXP_ERR 11
`define HESB_SUM_IO_ALM 12
`define HESB_SUM_EXP_ALM 13
`define HESB_SUM_IO_NOTE 14

// stored-data fault word fields
`define HESB_SD_EEPROM 4
`define HESB_SD_CALIB 5
`define HESB_SD_SETVAL 6
`define HESB_SD_CFGREG 8
`define HESB_SD_MODEL_INFO 9
`define HESB_SD_MODEL_MISMATCH 12

// configuration word a fields
`define HESB_CA_UNKNOWN 0
`define HESB_CA_TOO_MANY 2
`define HESB_CA_COMM_FAIL 3
`define HESB_CA_LOST 4

// unit count above which the too-many flag rises
`define HESB_MAX_UNITS 9

// axi-lite responses
`define HESB_RESP_OKAY 2'b00
`define HESB_RESP_SLVERR 2'b10

`endif

// *** rtl/hesb_status_bank.v ***
// Operation
// RULE1: summary bit0 follows any stored-data fault
// RULE2: summary bit1 ORs both configuration words
// RULE3: summary bit2 set while any channel errs
// RULE4: summary bit4 on expansion communication failure
// RULE5: summary bit10 follows local I/O error
// RULE6: summary bit11 on expansion unit error
// RULE7: summary bit12 follows local I/O alarm
// RULE8: summary bit13 on expansion unit alarm
// RULE9: summary bit14 follows I/O notification
// RULE10: config A bit0 unrecognised unit type
// RULE11: config A bit2 when units exceed 9
// RULE12: config A bit3 expansion communication failed
// RULE13: config A bit4 registered unit stopped responding
// RULE14: config B bit n-1 per-unit failure
// RULE15: unused bits zero, status writes ignored
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "hesb_defines.vh"

module hesb_status_bank #(
    parameter UNITS = 8,
    parameter CHANNELS = 4
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // fault sources, asynchronous levels
    input wire eeprom_fault,
    input wire calib_fault,
    input wire setval_fault,
    input wire cfgreg_fault,
    input wire model_info_fault,
    input wire model_mismatch_fault,
    input wire [CHANNELS-1:0] channel_err,
    input wire io_err,
    input wire io_alarm,
    input wire io_note,
    input wire exp_unit_err,
    input wire exp_unit_alarm,
    input wire unknown_unit,
    input wire [3:0] unit_count,
    input wire [UNITS-1:0] unit_comm_fail,
    input wire [UNITS-1:0] unit_registered,
    input wire [UNITS-1:0] unit_responding,
    // axi4-lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // axi4-lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [7:0] s_axi_araddr,
    // axi4-lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // interrupt
    output wire irq
);

    localparam NIN = 14 + CHANNELS + 4 + 3 * UNITS;

    // all fault pins pass two flops; only the second stage is read
    wire [NIN-1:0] raw_in;
    reg [NIN-1:0] sync1_reg;
    reg [NIN-1:0] sync2_reg;

    assign raw_in = {eeprom_fault, calib_fault, setval_fault, cfgreg_fault,
                     model_info_fault, model_mismatch_fault, io_err, io_alarm,
                     io_note, exp_unit_err, exp_unit_alarm, unknown_unit,
                     channel_err, unit_count, unit_comm_fail, unit_registered,
                     unit_responding, 2'b00};

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= {NIN{1'b0}};
            sync2_reg <= {NIN{1'b0}};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire s_eeprom = sync2_reg[NIN-1];
    wire s_calib = sync2_reg[NIN-2];
    wire s_setval = sync2_reg[NIN-3];
    wire s_cfgreg = sync2_reg[NIN-4];
    wire s_model_info = sync2_reg[NIN-5];
    wire s_model_mismatch = sync2_reg[NIN-6];
    wire s_io_err = sync2_reg[NIN-7];
    wire s_io_alarm = sync2_reg[NIN-8];
    wire s_io_note = sync2_reg[NIN-9];
    wire s_exp_err = sync2_reg[NIN-10];
    wire s_exp_alarm = sync2_reg[NIN-11];
    wire s_unknown = sync2_reg[NIN-12];
    wire [CHANNELS-1:0] s_chan = sync2_reg[NIN-13 -: CHANNELS];
    wire [3:0] s_count = sync2_reg[NIN-13-CHANNELS -: 4];
    wire [UNITS-1:0] s_fail = sync2_reg[3*UNITS+1 -: UNITS];
    wire [UNITS-1:0] s_regd = sync2_reg[2*UNITS+1 -: UNITS];
    wire [UNITS-1:0] s_resp = sync2_reg[UNITS+1 -: UNITS];

    // status words, rebuilt every cycle from synchronised levels
    reg [15:0] stored_word;
    reg [15:0] cfg_a_word;
    reg [15:0] unit_b_word;
    reg [15:0] summary_word;

    always @* begin
        stored_word = 16'h0000; // RULE15
        stored_word[`HESB_SD_EEPROM] = s_eeprom; // RULE1
        stored_word[`HESB_SD_CALIB] = s_calib; // RULE1
        stored_word[`HESB_SD_SETVAL] = s_setval; // RULE1
        stored_word[`HESB_SD_CFGREG] = s_cfgreg; // RULE1
        stored_word[`HESB_SD_MODEL_INFO] = s_model_info; // RULE1
        stored_word[`HESB_SD_MODEL_MISMATCH] = s_model_mismatch; // RULE1

        unit_b_word = 16'h0000; // RULE15
        unit_b_word[UNITS-1:0] = s_fail; // RULE14

        cfg_a_word = 16'h0000; // RULE15
        cfg_a_word[`HESB_CA_UNKNOWN] = s_unknown; // RULE10
        cfg_a_word[`HESB_CA_TOO_MANY] = (s_count > `HESB_MAX_UNITS); // RULE11
        cfg_a_word[`HESB_CA_COMM_FAIL] = |s_fail; // RULE12
        // a unit counts as lost only once registered in stored configuration
        cfg_a_word[`HESB_CA_LOST] = |(s_regd & ~s_resp); // RULE13

        summary_word = 16'h0000; // RULE15
        summary_word[`HESB_SUM_STORED] = |stored_word; // RULE1
        summary_word[`HESB_SUM_CONFIG] = |cfg_a_word | |unit_b_word; // RULE2
        summary_word[`HESB_SUM_CHANNEL] = |s_chan; // RULE3
        summary_word[`HESB_SUM_EXP_COMM] = |s_fail; // RULE4
        summary_word[`HESB_SUM_IO_ERR] = s_io_err; // RULE5
        summary_word[`HESB_SUM_EXP_ERR] = s_exp_err; // RULE6
        summary_word[`HESB_SUM_IO_ALM] = s_io_alarm; // RULE7
        summary_word[`HESB_SUM_EXP_ALM] = s_exp_alarm; // RULE8
        summary_word[`HESB_SUM_IO_NOTE] = s_io_note; // RULE9
    end

    // interrupts: rising summary bits set sticky status
    reg [15:0] summary_prev_reg;
    reg [15:0] irq_status_reg;
    reg [15:0] irq_mask_reg;
    wire [15:0] irq_event = summary_word & ~summary_prev_reg;

    assign irq = |(irq_status_reg & irq_mask_reg);

    // axi write path: address and data latched independently
    reg aw_held_reg;
    reg [7:0] aw_addr_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

    wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [3:0] wr_idx = aw_addr_reg[5:2];
    wire wr_mapped = (aw_addr_reg[7:6] == 2'b00) && (wr_idx <= `HESB_IDX_UNIT_COUNT);

    function [15:0] strb_mask;
        input [3:0] strb;
        begin
            strb_mask = {{8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    wire [15:0] wmask = w_data_reg[15:0] & strb_mask(w_strb_reg);
    wire clr_hit = wr_fire && (wr_idx == `HESB_IDX_IRQ_STATUS);
    wire [15:0] clr_bits = clr_hit ? wmask : 16'h0000;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            summary_prev_reg <= 16'h0000;
            irq_status_reg <= 16'h0000;
            irq_mask_reg <= 16'h0000;
        end else begin
            summary_prev_reg <= summary_word;
            // a new event wins over a clear in the same cycle
            irq_status_reg <= (irq_status_reg & ~clr_bits) | irq_event;
            if (wr_fire && wr_idx == `HESB_IDX_IRQ_MASK) begin
                irq_mask_reg <= (irq_mask_reg & ~strb_mask(w_strb_reg)) | wmask;
            end
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HESB_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // status words accept the write silently and keep their value
                s_axi_bresp <= wr_mapped ? `HESB_RESP_OKAY : `HESB_RESP_SLVERR; // RULE15
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read path: one outstanding read
    assign s_axi_arready = !s_axi_rvalid;
    wire [3:0] rd_idx = s_axi_araddr[5:2];

    reg [15:0] rd_word;
    reg rd_ok;
    always @* begin
        rd_ok = (s_axi_araddr[7:6] == 2'b00);
        case (rd_idx)
            `HESB_IDX_SUMMARY: rd_word = summary_word;
            `HESB_IDX_STORED: rd_word = stored_word;
            `HESB_IDX_CFG_A: rd_word = cfg_a_word;
            `HESB_IDX_UNIT_B: rd_word = unit_b_word;
            `HESB_IDX_IRQ_STATUS: rd_word = irq_status_reg;
            `HESB_IDX_IRQ_MASK: rd_word = irq_mask_reg;
            `HESB_IDX_UNIT_COUNT: rd_word = {12'h000, s_count};
            default: begin
                rd_word = 16'h0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HESB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? {16'h0000, rd_word} : 32'h00000000; // RULE15
            s_axi_rresp <= rd_ok ? `HESB_RESP_OKAY : `HESB_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // hesb_status_bank

// *** verif/hesb_properties.sv ***
`timescale 1ns/1ns
module hesb_properties (
    // bus handshakes and read data
    input wire sys_clk, arst_n, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire [7:0] s_axi_araddr,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp, s_axi_bresp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    reg [7:0] ar_reg;
    // bits that no status word uses, per word
    wire [15:0] dead = ar_reg == 8'h00 ? 16'h83e8 : ar_reg == 8'h04 ? 16'hec8f :
        ar_reg == 8'h08 ? 16'hffe2 : ar_reg == 8'h0c ? 16'hff00 : 16'h0000;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) ar_reg <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready) ar_reg <= s_axi_araddr;
    end
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_b_block; s_axi_bvalid |-> !s_axi_awready; endproperty
    property p_hi_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    property p_unused; s_axi_rvalid |-> (s_axi_rdata[15:0] & dead) == 16'h0000; endproperty
    property p_unmapped; s_axi_rvalid && ar_reg >= 8'h1c |-> s_axi_rresp == 2'h2; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_ar_block: assert property (p_ar_block) else $error("read address taken early");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_b_block: assert property (p_b_block) else $error("write address taken early");
    a_hi_zero: assert property (p_hi_zero) else $error("upper half set");
    a_unused: assert property (p_unused) else $error("unused bit set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read okay");
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // hesb_properties
bind hesb_status_bank hesb_properties u_props (.*);

// *** verif/hesb_host.sv ***
`timescale 1ns/1ns
module hesb_host (
    // master side of the register bus
    input wire sys_clk,
    output reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    output reg [7:0] s_axi_awaddr, s_axi_araddr,
    output reg [31:0] s_axi_wdata,
    output reg [3:0] s_axi_wstrb,
    input wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_bresp, s_axi_rresp
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end
    // handshakes are judged just after each rising edge, before that edge's updates land
    task rd(input [7:0] a, output [31:0] d, output [1:0] r, output bit ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin @(posedge sys_clk); n++; end while (!s_axi_arready && n < 64);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do begin @(posedge sys_clk); n++; end while (!s_axi_rvalid && n < 64);
        d = s_axi_rdata;
        r = s_axi_rresp;
        ok = n < 64;
        s_axi_rready <= 1'b0;
    endtask
    task wr(input [7:0] a, input [31:0] v, output [1:0] r, output bit ok);
        int n;
        bit ta, tw;
        {n, ta, tw} = 0;
        @(posedge sys_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        while (!(ta && tw) && n < 64) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin @(posedge sys_clk); n++; end while (!s_axi_bvalid && n < 64);
        r = s_axi_bresp;
        ok = n < 64;
        s_axi_bready <= 1'b0;
    endtask
endmodule // hesb_host

// *** verif/hierarchical_error_status_bank_tb.sv ***
`timescale 1ns/1ns
module hierarchical_error_status_bank_tb;
    reg sys_clk, arst_n;
    reg [43:0] pat;
    int mismatches, cmp_count;
    wire eeprom_fault, calib_fault, setval_fault, cfgreg_fault, model_info_fault;
    wire model_mismatch_fault, io_err, io_alarm, io_note, exp_unit_err, exp_unit_alarm;
    wire unknown_unit, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire [3:0] unit_count, channel_err, s_axi_wstrb;
    wire [7:0] unit_comm_fail, unit_registered, unit_responding, s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    assign {unit_responding, unit_registered, unit_comm_fail, unit_count, unknown_unit,
        exp_unit_alarm, exp_unit_err, io_note, io_alarm, io_err, channel_err,
        model_mismatch_fault, model_info_fault, cfgreg_fault, setval_fault, calib_fault,
        eeprom_fault} = pat;
    hesb_status_bank DUT (.*);
    hesb_host u_host (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bit ok;
        u_host.rd(a, d, r, ok);
        if (!ok) begin mismatches++; test_done; end
        chk("rdata", d, e);
        chk("rresp", {30'h0, r}, {30'h0, er});
    endtask
    task wr(input [7:0] a, input [31:0] v, input [1:0] er);
        logic [1:0] r;
        bit ok;
        u_host.wr(a, v, r, ok);
        if (!ok) begin mismatches++; test_done; end
        chk("bresp", {30'h0, r}, {30'h0, er});
    endtask
    task irq_is(input e);
        @(negedge sys_clk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    // two sync flops plus the interrupt status register settle within four edges
    task setp(input [43:0] p, input [7:0] a, input [15:0] w, input [15:0] s);
        @(posedge sys_clk);
        pat <= p;
        repeat (4) @(posedge sys_clk);
        rd(a, {16'h0, w}, 2'b00);
        rd(8'h00, {16'h0, s}, 2'b00);
    endtask
    task t_regs;
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, 2'b00);
        rd(8'h1c, 32'h0, 2'b10);
        wr(8'h00, 32'hffff_ffff, 2'b00);
        rd(8'h00, 32'h0, 2'b00);
        wr(8'h1c, 32'h1, 2'b10);
        $display("t_regs done");
    endtask
    task t_stored;
        int b[6] = '{4, 5, 6, 8, 9, 12};
        for (int i = 0; i < 6; i++) setp(44'h1 << i, 8'h04, 16'h1 << b[i], 16'h0001);
        $display("t_stored done");
    endtask
    task t_sum;
        int p[7] = '{6, 9, 10, 11, 12, 13, 14};
        int s[7] = '{2, 2, 10, 12, 14, 11, 13};
        for (int i = 0; i < 7; i++) setp(44'h1 << p[i], 8'h00, 16'h1 << s[i], 16'h1 << s[i]);
        $display("t_sum done");
    endtask
    task t_cfg;
        setp(44'h1 << 15, 8'h08, 16'h0001, 16'h0002);
        setp(44'h9 << 16, 8'h08, 16'h0000, 16'h0000);
        setp(44'ha << 16, 8'h08, 16'h0004, 16'h0002);
        rd(8'h18, 32'h0000_000a, 2'b00);
        setp(44'h1 << 27, 8'h08, 16'h0008, 16'h0012);
        for (int i = 0; i < 8; i++) setp(44'h1 << (20 + i), 8'h0c, 16'h1 << i, 16'h0012);
        setp(44'h1 << 31, 8'h08, 16'h0010, 16'h0002);
        setp(44'h101 << 31, 8'h08, 16'h0000, 16'h0000);
        $display("t_cfg done");
    endtask
    task t_irq;
        setp(44'h0, 8'h00, 16'h0000, 16'h0000);
        wr(8'h10, 32'hffff, 2'b00);
        wr(8'h14, 32'h0400, 2'b00);
        rd(8'h14, 32'h0400, 2'b00);
        irq_is(1'b0);
        setp(44'h1 << 10, 8'h10, 16'h0400, 16'h0400);
        irq_is(1'b1);
        wr(8'h14, 32'h0, 2'b00);
        irq_is(1'b0);
        wr(8'h14, 32'h0400, 2'b00);
        setp(44'h0, 8'h10, 16'h0400, 16'h0000);
        irq_is(1'b1);
        wr(8'h10, 32'h0400, 2'b00);
        irq_is(1'b0);
        rd(8'h10, 32'h0, 2'b00);
        $display("t_irq done");
    endtask
    initial begin
        pat = 44'h0;
        arst_n = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs;
        t_stored;
        t_sum;
        t_cfg;
        t_irq;
        test_done;
    end
endmodule // hierarchical_error_status_bank_tb
